// >>> src/sarm_params.svh
// Purpose: constants for the acceleration range monitor
// Assumes: one clock, synchronous active-high reset
// Notes:   register offsets are word indices times four
`ifndef SARM_PARAMS_SVH
`define SARM_PARAMS_SVH

`define SARM_ACC_W          16
`define SARM_NUM_INST       3
`define SARM_NUM_SDI        4
`define SARM_NUM_SDO        4

`define SARM_ADDR_W         8
// per-instance block of four words: base = instance * 0x10
`define SARM_INST_STRIDE    8'h10
`define SARM_OFF_UPPER      8'h00
`define SARM_OFF_LOWER      8'h04
`define SARM_OFF_CTRL       8'h08
`define SARM_OFF_STATE      8'h0c
`define SARM_OFF_IRQ_STAT   8'h30
`define SARM_OFF_IRQ_MASK   8'h34
`define SARM_OFF_SDO_MAP    8'h38

// control word fields
`define SARM_CTRL_FSOE_EN   0
`define SARM_CTRL_SDI_LSB   1
`define SARM_CTRL_SDI_W     3
`define SARM_CTRL_REACT_LSB 4
`define SARM_CTRL_REACT_W   2

`define SARM_RST_UPPER      16'h0001
`define SARM_RST_LOWER      16'h0001
`define SARM_RST_REACT      2'h1
`define SARM_STATE_FAILED   2'h2

`endif

// >>> src/sarm_pkg.sv
// Purpose: types for the acceleration range monitor
// Assumes: sarm_params.svh defines the widths
// Notes:   reaction codes follow the configured selection values
`include "sarm_params.svh"
package sarm_pkg;
    typedef logic signed [`SARM_ACC_W-1:0] sarm_accel_t;
    typedef enum logic [1:0] {
        SARM_REACT_NONE    = 2'h0,
        SARM_REACT_TORQUE  = 2'h1,
        SARM_REACT_STOP1   = 2'h2,
        SARM_REACT_STOP2   = 2'h3
    } sarm_react_t;
    // declaration order fixes the reported encoding: failed reads back as 2
    typedef enum logic [1:0] {
        SARM_ST_IDLE,
        SARM_ST_MONITOR,
        SARM_ST_FAILED
    } sarm_state_t;
endpackage : sarm_pkg

// >>> src/sarm_instance.sv
// Purpose: one acceleration range monitor instance
// Assumes: sample strobe marks each new safe acceleration value
// Notes:   failure latches until deactivated
`include "sarm_params.svh"
module sarm_instance (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 activate,
    input  wire logic                 sampleValid,
    input  wire sarm_pkg::sarm_accel_t safeAccel,
    input  wire sarm_pkg::sarm_accel_t accelUpperLimit,
    input  wire sarm_pkg::sarm_accel_t accelLowerLimit,
    output logic                      active,
    output logic                      faultActivate,
    output sarm_pkg::sarm_state_t     internalState,
    output logic                      violationPulse
);
    import sarm_pkg::*;

    sarm_state_t state_q;
    logic        fault_q;
    logic        violPulse_q;
    wire         outside = (safeAccel > accelUpperLimit) || (safeAccel < accelLowerLimit);
    wire         hit     = sampleValid && outside;

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q     <= SARM_ST_IDLE;
            fault_q     <= 1'b0;
            violPulse_q <= 1'b0;
        end else begin
            violPulse_q <= 1'b0;
            case (state_q)
                SARM_ST_IDLE: begin
                    fault_q <= 1'b0;
                    if (activate) begin
                        state_q <= SARM_ST_MONITOR;
                    end
                end
                SARM_ST_MONITOR: begin
                    if (!activate) begin
                        state_q <= SARM_ST_IDLE;
                    end else if (hit) begin
                        state_q     <= SARM_ST_FAILED;
                        fault_q     <= 1'b1;
                        violPulse_q <= 1'b1;
                    end
                end
                SARM_ST_FAILED: begin
                    // stays active while the fault reaction runs
                    if (!activate) begin
                        state_q <= SARM_ST_IDLE;
                        fault_q <= 1'b0;
                    end
                end
                default: state_q <= SARM_ST_IDLE;
            endcase
        end
    end

    assign active         = (state_q != SARM_ST_IDLE);
    assign faultActivate  = fault_q;
    assign internalState  = state_q;
    assign violationPulse = violPulse_q;
endmodule : sarm_instance

// >>> src/sarm_monitor.sv
// Purpose: acceleration range monitor, three instances for one axis
// Assumes: register port master as described; safe inputs are asynchronous pins
// Notes:   fault reaction requests are ORed per reaction kind
//
// Summary of operation
// - active instance compares safe acceleration to window, fires reaction when outside.
// - window bounded by separate upper and lower acceleration limits.
// - three independent instances per axis with own limits, source, reaction, status.
// - activation only by fieldbus request or a mapped safe input.
// - measured value comes only from the safe feedback acceleration.
// - each instance outputs active status and a fault activation request.
// - fault activation starts the configured reaction on window violation.
// - reaction selectable; default torque removal (1), else stop one (2), stop two (3) or none (0).
// - after firing the instance stays active, internal state failed (2).
// - two safe outputs carrying active status may pair as dual channel.
`include "sarm_params.svh"
module sarm_monitor (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic [`SARM_ADDR_W-1:0]       regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic [31:0]                        regRdata,
    input  wire logic                          safeAccelValid,
    input  wire sarm_pkg::sarm_accel_t         safeAccel,
    input  wire logic [`SARM_NUM_INST-1:0]     fsoeActivate,
    input  wire logic [`SARM_NUM_SDI-1:0]      safeInput,
    output logic [`SARM_NUM_INST-1:0]          monitorActiveStatus,
    output logic [`SARM_NUM_INST-1:0]          faultActivate,
    output logic                               safeTorqueRemovalReq,
    output logic                               safeStopOneReq,
    output logic                               safeStopTwoReq,
    output logic [`SARM_NUM_SDO-1:0]           safeOutput,
    output logic                               irq
);
    import sarm_pkg::*;

    localparam int NI = `SARM_NUM_INST;

    // pin synchroniser: first stage feeds only the second
    logic [`SARM_NUM_SDI-1:0] sdiMeta_q;
    logic [`SARM_NUM_SDI-1:0] sdiSync_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            sdiMeta_q <= '0;
            sdiSync_q <= '0;
        end else begin
            sdiMeta_q <= safeInput;
            sdiSync_q <= sdiMeta_q;
        end
    end

    // safe acceleration registered on same clock, valid kept aligned
    sarm_accel_t accel_q;
    logic        accelValid_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            accel_q      <= '0;
            accelValid_q <= 1'b0;
        end else begin
            accel_q      <= safeAccel;
            accelValid_q <= safeAccelValid;
        end
    end

    sarm_accel_t           upper_q [NI];
    sarm_accel_t           lower_q [NI];
    logic [7:0]            ctrl_q  [NI];
    logic [NI-1:0]         irqStat_q;
    logic [NI-1:0]         irqMask_q;
    // per output: [1:0] instance select (3 = off), [2] enable, [3] on an even output pairs the next odd output with it
    logic [15:0]           sdoMap_q;

    logic [NI-1:0]         instActive;
    logic [NI-1:0]         instFault;
    logic [NI-1:0]         instViol;
    logic [NI-1:0]         instAct;
    sarm_state_t           instState [NI];
    logic [NI-1:0]         wrUpper;
    logic [NI-1:0]         wrLower;
    logic [NI-1:0]         wrCtrl;

    wire wrIrqStat = regWrite && (regAddr == `SARM_OFF_IRQ_STAT);
    wire wrIrqMask = regWrite && (regAddr == `SARM_OFF_IRQ_MASK);
    wire wrSdoMap  = regWrite && (regAddr == `SARM_OFF_SDO_MAP);

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_inst
            localparam logic [7:0] BASE = 8'(gi * `SARM_INST_STRIDE);
            wire [`SARM_CTRL_SDI_W-1:0] sdiSel =
                ctrl_q[gi][`SARM_CTRL_SDI_LSB +: `SARM_CTRL_SDI_W];
            // sdiSel 0 means not used; 1..n picks a safe input
            wire sdiHit = (sdiSel != '0) && (sdiSel <= `SARM_NUM_SDI)
                          && sdiSync_q[2'(sdiSel - 3'h1)];
            assign instAct[gi] = (ctrl_q[gi][`SARM_CTRL_FSOE_EN] && fsoeActivate[gi])
                                 || sdiHit;
            assign wrUpper[gi] = regWrite && (regAddr == BASE + `SARM_OFF_UPPER);
            assign wrLower[gi] = regWrite && (regAddr == BASE + `SARM_OFF_LOWER);
            assign wrCtrl[gi]  = regWrite && (regAddr == BASE + `SARM_OFF_CTRL);

            always_ff @(posedge clock) begin
                if (rst) begin
                    upper_q[gi] <= `SARM_RST_UPPER;
                    lower_q[gi] <= `SARM_RST_LOWER;
                    ctrl_q[gi]  <= {2'h0, `SARM_RST_REACT, 4'h0};
                end else begin
                    if (wrUpper[gi]) upper_q[gi] <= regWdata[`SARM_ACC_W-1:0];
                    if (wrLower[gi]) lower_q[gi] <= regWdata[`SARM_ACC_W-1:0];
                    if (wrCtrl[gi])  ctrl_q[gi]  <= regWdata[7:0];
                end
            end

            sarm_instance u_inst (
                .clock           (clock),
                .rst             (rst),
                .activate        (instAct[gi]),
                .sampleValid     (accelValid_q),
                .safeAccel       (accel_q),
                .accelUpperLimit (upper_q[gi]),
                .accelLowerLimit (lower_q[gi]),
                .active          (instActive[gi]),
                .faultActivate   (instFault[gi]),
                .internalState   (instState[gi]),
                .violationPulse  (instViol[gi])
            );
        end
    endgenerate

    // fault reaction dispatch per selected kind
    logic [NI-1:0] selTorque;
    logic [NI-1:0] selStop1;
    logic [NI-1:0] selStop2;
    always_comb begin
        for (int i = 0; i < NI; i++) begin
            selTorque[i] = ctrl_q[i][`SARM_CTRL_REACT_LSB +: 2] == SARM_REACT_TORQUE;
            selStop1[i]  = ctrl_q[i][`SARM_CTRL_REACT_LSB +: 2] == SARM_REACT_STOP1;
            selStop2[i]  = ctrl_q[i][`SARM_CTRL_REACT_LSB +: 2] == SARM_REACT_STOP2;
        end
    end
    wire reqTorque = |(instFault & selTorque);
    wire reqStop1  = |(instFault & selStop1);
    wire reqStop2  = |(instFault & selStop2);

    // safe output routing; an unmapped output stays low unless it is an odd output paired with its even neighbour
    logic [`SARM_NUM_SDO-1:0] sdoD;
    always_comb begin
        logic [3:0] f;
        f = 4'h0;
        for (int o = 0; o < `SARM_NUM_SDO; o++) begin
            f = sdoMap_q[o*4 +: 4];
            sdoD[o] = f[2] && (f[1:0] != 2'h3) && instActive[f[1:0]];
        end
        // paired outputs: odd follows even so both channels switch together
        for (int o = 1; o < `SARM_NUM_SDO; o += 2) begin
            if (sdoMap_q[(o-1)*4 + 3]) begin
                sdoD[o] = sdoD[o-1];
            end
        end
    end

    // interrupt: set wins over write-one-to-clear
    wire [NI-1:0] irqStatD = (irqStat_q & ~(wrIrqStat ? regWdata[NI-1:0] : '0)) | instViol;

    // read mux
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        for (int i = 0; i < NI; i++) begin
            if (regAddr == 8'(i * `SARM_INST_STRIDE) + `SARM_OFF_UPPER)
                rdMux = {{(32-`SARM_ACC_W){upper_q[i][`SARM_ACC_W-1]}}, upper_q[i]};
            if (regAddr == 8'(i * `SARM_INST_STRIDE) + `SARM_OFF_LOWER)
                rdMux = {{(32-`SARM_ACC_W){lower_q[i][`SARM_ACC_W-1]}}, lower_q[i]};
            if (regAddr == 8'(i * `SARM_INST_STRIDE) + `SARM_OFF_CTRL)
                rdMux = {24'h0, ctrl_q[i]};
            if (regAddr == 8'(i * `SARM_INST_STRIDE) + `SARM_OFF_STATE)
                rdMux = {28'h0, instFault[i], instActive[i], instState[i]};
        end
        if (regAddr == `SARM_OFF_IRQ_STAT) rdMux = {29'h0, irqStat_q};
        if (regAddr == `SARM_OFF_IRQ_MASK) rdMux = {29'h0, irqMask_q};
        if (regAddr == `SARM_OFF_SDO_MAP)  rdMux = {16'h0, sdoMap_q};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irqStat_q            <= '0;
            irqMask_q            <= '0;
            sdoMap_q             <= 16'h0;
            regRdata             <= 32'h0;
            monitorActiveStatus  <= '0;
            faultActivate        <= '0;
            safeTorqueRemovalReq <= 1'b0;
            safeStopOneReq       <= 1'b0;
            safeStopTwoReq       <= 1'b0;
            safeOutput           <= '0;
            irq                  <= 1'b0;
        end else begin
            irqStat_q            <= irqStatD;
            if (wrIrqMask) irqMask_q <= regWdata[NI-1:0];
            if (wrSdoMap)  sdoMap_q  <= regWdata[15:0];
            regRdata             <= regRead ? rdMux : 32'h0;
            monitorActiveStatus  <= instActive;
            faultActivate        <= instFault;
            safeTorqueRemovalReq <= reqTorque;
            safeStopOneReq       <= reqStop1;
            safeStopTwoReq       <= reqStop2;
            safeOutput           <= sdoD;
            irq                  <= |(irqStatD & irqMask_q);
        end
    end
endmodule : sarm_monitor

// >>> verif/sarm_source_model.sv
// Purpose: safe acceleration source and activation inputs
// Assumes: bench sets commanded values at rising edges
// Notes:   sample bus is scrambled between strobes
module sarm_source_model #(
    parameter int Period = 4
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire sarm_pkg::sarm_accel_t accelCmd,
    input  wire logic [2:0]            fsoeCmd,
    input  wire logic [3:0]            sdiCmd,
    output logic                       safeAccelValid,
    output sarm_pkg::sarm_accel_t      safeAccel,
    output logic [2:0]                 fsoeActivate,
    output logic [3:0]                 safeInput
);
    timeunit 1ns;
    timeprecision 1ns;
    import sarm_pkg::*;
    logic [3:0] phase_q;
    always_ff @(posedge clock) begin
        phase_q        <= (rst || phase_q == 4'(Period - 1)) ? 4'h0 : phase_q + 4'h1;
        safeAccelValid <= !rst && phase_q == 4'h0;
        // a stale sample must never look valid, so show its inverse
        safeAccel      <= (phase_q == 4'h0) ? accelCmd : ~accelCmd;
        fsoeActivate   <= fsoeCmd;
        safeInput      <= sdiCmd;
    end
endmodule : sarm_source_model

// >>> verif/sarm_monitor_checker.sv
// Purpose: port assertions for the acceleration range monitor
// Assumes: sees only sarm_monitor ports
// Notes:   source age counter bounds activation latency
`include "sarm_params.svh"
module sarm_monitor_checker (
    input wire logic                      clock,
    input wire logic                      rst,
    input wire logic                      safeAccelValid,
    input wire logic [`SARM_NUM_INST-1:0] fsoeActivate,
    input wire logic [`SARM_NUM_SDI-1:0]  safeInput,
    input wire logic [`SARM_NUM_INST-1:0] monitorActiveStatus,
    input wire logic [`SARM_NUM_INST-1:0] faultActivate,
    input wire logic                      safeTorqueRemovalReq,
    input wire logic                      safeStopOneReq,
    input wire logic                      safeStopTwoReq,
    input wire logic [`SARM_NUM_SDO-1:0]  safeOutput
);
    timeunit 1ns;
    timeprecision 1ns;
    import sarm_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    torque_req_a: assert property (safeTorqueRemovalReq |-> |faultActivate)
        else $error("torque request without fault");
    stop_one_a: assert property (safeStopOneReq |-> |faultActivate)
        else $error("stop one request without fault");
    stop_two_a: assert property (safeStopTwoReq |-> |faultActivate)
        else $error("stop two request without fault");
    out_status_a: assert property (|safeOutput |-> |monitorActiveStatus ||
        |$past(monitorActiveStatus)) else $error("output without active status");
    for (genvar i = 0; i < `SARM_NUM_INST; i++) begin : g_inst
        logic [3:0] srcAge_q;
        logic [3:0] srcAge_d;
        // any safe input counts: the mapping is not visible at the ports
        assign srcAge_d = (fsoeActivate[i] || |safeInput) ? 4'h0 :
                          (srcAge_q == 4'hf) ? 4'hf : srcAge_q + 4'h1;
        always_ff @(posedge clock) begin
            srcAge_q <= rst ? 4'hf : srcAge_d;
        end
        sequence quietInst;
            !monitorActiveStatus[i] [*3];
        endsequence
        sequence faultStart;
            $rose(faultActivate[i]);
        endsequence
        fault_active_a: assert property (faultStart |-> monitorActiveStatus[i])
            else $error("fault while inactive");
        fault_hold_a: assert property (
            $fell(faultActivate[i]) |-> ##[0:1] !monitorActiveStatus[i])
            else $error("fault dropped while active");
        inactive_quiet_a: assert property (quietInst |-> !faultActivate[i])
            else $error("inactive instance faults");
        act_source_a: assert property ($rose(monitorActiveStatus[i]) |-> srcAge_q < 4'h8)
            else $error("activation without request");
        fault_sample_a: assert property (faultStart |-> $past(safeAccelValid, 3))
            else $error("fault not tied to a sample");
    end
endmodule : sarm_monitor_checker
bind sarm_monitor sarm_monitor_checker chk (.clock, .rst, .safeAccelValid, .fsoeActivate,
    .safeInput, .monitorActiveStatus, .faultActivate, .safeTorqueRemovalReq,
    .safeStopOneReq, .safeStopTwoReq, .safeOutput);

// >>> verif/tb_sarm_monitor.sv
// Purpose: register-level test of the acceleration range monitor
// Assumes: source model strobes a sample every four cycles
// Notes:   latencies checked by bounded polling
module tb_sarm_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    import sarm_pkg::*;
    logic        clock, rst, regWrite, regRead, safeAccelValid, irq;
    logic        safeTorqueRemovalReq, safeStopOneReq, safeStopTwoReq;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    logic [2:0]  fsoeCmd, fsoeActivate, monitorActiveStatus, faultActivate;
    logic [3:0]  sdiCmd, safeInput, safeOutput;
    sarm_accel_t safeAccel, accelCmd;
    int          mismatches, checkCount;
    sarm_monitor dut (.clock, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .safeAccelValid, .safeAccel, .fsoeActivate, .safeInput, .monitorActiveStatus,
        .faultActivate, .safeTorqueRemovalReq, .safeStopOneReq, .safeStopTwoReq,
        .safeOutput, .irq);
    sarm_source_model src (.clock, .rst, .accelCmd, .fsoeCmd, .sdiCmd, .safeAccelValid,
        .safeAccel, .fsoeActivate, .safeInput);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finishTest();
        if (mismatches == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finishTest
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        check($sformatf("reg %h", a), regRdata, exp);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic setIn(input sarm_accel_t a, input logic [2:0] f, input logic [3:0] s);
        @(posedge clock);
        accelCmd <= a;
        fsoeCmd  <= f;
        sdiCmd   <= s;
        #1;
    endtask : setIn
    task automatic waitOut(input logic [2:0] act, input logic [2:0] flt);
        int n;
        n = 0;
        while ((monitorActiveStatus !== act || faultActivate !== flt) && n < 30) begin
            idle(1);
            n++;
        end
        check("monitorActiveStatus", 32'(monitorActiveStatus), 32'(act));
        check("faultActivate", 32'(faultActivate), 32'(flt));
        if (n == 30) mismatches++;
    endtask : waitOut
    task automatic reqs(input logic [2:0] exp);
        check("reaction requests", 32'({safeStopTwoReq, safeStopOneReq,
              safeTorqueRemovalReq}), 32'(exp));
    endtask : reqs
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        {rst, regWrite, regRead, regAddr, regWdata} = {1'b1, 42'h0};
        {accelCmd, fsoeCmd, sdiCmd, mismatches, checkCount} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h1);
        rd(8'h18, 32'h10);
        rd(8'h3c, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(8'(i * 16), 32'(100 + i * 10));
            wr(8'(i * 16 + 4), 32'hffffff9c);
            wr(8'(i * 16 + 8), 32'(((i + 1) << 4) | 1));
        end
        wr(8'h34, 32'h0);
        rd(8'h24, 32'hffffff9c);
        setIn(16'sd0, 3'b111, 4'h0);
        waitOut(3'b111, 3'b000);
        rd(8'h0c, 32'h5);
        setIn(16'sd100, 3'b111, 4'h0);
        idle(12);
        check("faultActivate", 32'(faultActivate), 32'h0);
        setIn(-16'sd100, 3'b111, 4'h0);
        idle(12);
        check("faultActivate", 32'(faultActivate), 32'h0);
        setIn(16'sd111, 3'b111, 4'h0);
        waitOut(3'b111, 3'b011);
        reqs(3'b011);
        check("irq", 32'(irq), 32'h0);
        setIn(16'sd121, 3'b111, 4'h0);
        waitOut(3'b111, 3'b111);
        reqs(3'b111);
        setIn(16'sd0, 3'b111, 4'h0);
        idle(12);
        waitOut(3'b111, 3'b111);
        rd(8'h2c, 32'he);
        rd(8'h30, 32'h7);
        wr(8'h34, 32'h7);
        idle(2);
        check("irq", 32'(irq), 32'h1);
        wr(8'h30, 32'h7);
        idle(2);
        check("irq", 32'(irq), 32'h0);
        setIn(16'sd0, 3'b000, 4'h0);
        waitOut(3'b000, 3'b000);
        wr(8'h18, 32'h24);
        wr(8'h28, 32'h08);
        setIn(16'sd0, 3'b100, 4'b0010);
        waitOut(3'b010, 3'b000);
        check("safeOutput", 32'(safeOutput), 32'h0);
        wr(8'h38, 32'hd);
        idle(3);
        check("safeOutput", 32'(safeOutput), 32'h3);
        setIn(-16'sd101, 3'b100, 4'b1010);
        waitOut(3'b110, 3'b110);
        reqs(3'b010);
        check("irq", 32'(irq), 32'h1);
        setIn(16'sd0, 3'b000, 4'h0);
        waitOut(3'b000, 3'b000);
        idle(3);
        check("safeOutput", 32'(safeOutput), 32'h0);
        finishTest();
    end
endmodule : tb_sarm_monitor
